// ==== hdl/dtc_timer_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dtc_cfg.svh"

// Summary of operation
// - Timer operation adds one per machine cycle of six clocks.
// - Counter operation samples its pin per machine cycle; high then low counts.
// - Count from a detected edge appears in the following machine cycle.
// - Mode register: timer 1 in bits 7..4, timer 0 in bits 3..0.
// - Count only while run bit set and gating clear or interrupt pin high.
// - Select bit clear counts machine cycles; set counts own pin edges.
// - Mode 00 is 13 bits: high byte plus low five bits of low byte.
// - Rollover from all ones to zeros sets the overflow flag.
// - Setting a run bit leaves the count bytes untouched.
// - Mode 01 cascades both bytes into a full 16-bit counter.
// - Mode 10 counts low byte, reloads it from high byte on overflow.
// - Timer 1 in mode 11 stops and holds, as if run cleared.
// - Timer 0 mode 11 splits; high byte uses timer 1 run and flag.
// - Timer 1 still runs unless mode 11 and feeds the serial port.
// - Overflow flags set by hardware, cleared by vectoring or software.
// - Run bits at control bits 6 and 4 start and stop timers.
// - External flags set by edge or low level, cleared by service or software.
// - Type bits select falling edge or low level triggering.
// - Mode and control registers reset to all zeros.
module dtc_timer_unit #(
	parameter int CYCLE_CLKS = `DTC_CYCLE_CLKS
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Register access from the core
	input wire dtc_pkg::dtc_sfr_req_t SFR_REQ,
	output logic [7:0] SFR_RDATA,
	// Pins
	input wire logic COUNT_PIN_ZERO,
	input wire logic COUNT_PIN_ONE,
	input wire logic EXT_IRQ_PIN_ZERO,
	input wire logic EXT_IRQ_PIN_ONE,
	// Interrupt service acknowledges
	input wire logic ACK_OVF_ZERO,
	input wire logic ACK_OVF_ONE,
	input wire logic ACK_EXT_ZERO,
	input wire logic ACK_EXT_ONE,
	// Interrupt requests
	output logic OVF_REQ_ZERO,
	output logic OVF_REQ_ONE,
	output logic EXT_REQ_ZERO,
	output logic EXT_REQ_ONE,
	// Timer 1 overflow for the serial port
	output logic SERIAL_TICK
);
	import dtc_pkg::*;

	// ==============================
	// Count step for one timer
	function automatic dtc_step_t count_step(input dtc_mode_t mode, input logic [7:0] hi,
		input logic [7:0] lo);
		dtc_step_t s;
		logic [12:0] v13;
		logic [15:0] v16;
		s.hi = hi;
		s.lo = lo;
		s.ovf = 1'b0;
		v13 = {hi, lo[4:0]} + 13'h0001;
		v16 = {hi, lo} + 16'h0001;
		case (mode)
			DTC_MODE_13BIT:
			begin
				// upper three low bits left as they are
				s.ovf = ({hi, lo[4:0]} == 13'h1FFF);
				s.hi = v13[12:5];
				s.lo[4:0] = v13[4:0];
			end
			DTC_MODE_16BIT:
			begin
				s.ovf = ({hi, lo} == 16'hFFFF);
				s.hi = v16[15:8];
				s.lo = v16[7:0];
			end
			DTC_MODE_RELOAD:
			begin
				// reload low byte from high byte
				s.ovf = (lo == 8'hFF);
				s.lo = s.ovf ? hi : lo + 8'h01;
			end
			default:
			begin
				s.ovf = (lo == 8'hFF);
				s.lo = lo + 8'h01;
			end
		endcase
		return s;
	endfunction

	// ==============================
	// Registers
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [7:0] mode_q;
	logic [7:0] lo0_q;
	logic [7:0] lo0_d;
	logic [7:0] hi0_q;
	logic [7:0] hi0_d;
	logic [7:0] lo1_q;
	logic [7:0] lo1_d;
	logic [7:0] hi1_q;
	logic [7:0] hi1_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic serial_q;

	// ==============================
	// Machine cycle and pin sampling
	wire logic mc_en;
	wire logic [3:0] pins = {EXT_IRQ_PIN_ONE, EXT_IRQ_PIN_ZERO, COUNT_PIN_ONE, COUNT_PIN_ZERO};
	wire logic [3:0] level;
	wire logic [3:0] fall;

	dtc_cycle_div #(
		.CYCLE_CLKS(CYCLE_CLKS)
	) u_div (
		.clk(CLK),
		.rst(RST),
		.en_q(mc_en)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_samp
			dtc_pin_sampler u_samp (
				.clk(CLK),
				.rst(RST),
				.mc_en(mc_en),
				.pin(pins[gi]),
				.level_q(level[gi]),
				.fall_q(fall[gi])
			);
		end
	endgenerate

	// ==============================
	// Register access decode
	wire logic wr_ctrl = SFR_REQ.wr && (SFR_REQ.addr == `DTC_ADDR_CTRL_FLAGS);
	wire logic wr_mode = SFR_REQ.wr && (SFR_REQ.addr == `DTC_ADDR_MODE_SEL);
	wire logic wr_lo0 = SFR_REQ.wr && (SFR_REQ.addr == `DTC_ADDR_CNT0_LO);
	wire logic wr_hi0 = SFR_REQ.wr && (SFR_REQ.addr == `DTC_ADDR_CNT0_HI);
	wire logic wr_lo1 = SFR_REQ.wr && (SFR_REQ.addr == `DTC_ADDR_CNT1_LO);
	wire logic wr_hi1 = SFR_REQ.wr && (SFR_REQ.addr == `DTC_ADDR_CNT1_HI);

	// ==============================
	// Mode select fields
	// per-timer field layout
	wire logic gate0 = mode_q[`DTC_GATE_ZERO_BIT];
	wire logic sel0 = mode_q[`DTC_SEL_ZERO_BIT];
	wire dtc_mode_t mode0 = dtc_mode_t'(mode_q[`DTC_MODE_ZERO_HI:`DTC_MODE_ZERO_LO]);
	wire logic gate1 = mode_q[`DTC_GATE_ONE_BIT];
	wire logic sel1 = mode_q[`DTC_SEL_ONE_BIT];
	wire dtc_mode_t mode1 = dtc_mode_t'(mode_q[`DTC_MODE_ONE_HI:`DTC_MODE_ONE_LO]);
	wire logic run0 = ctrl_q[`DTC_RUN_ZERO_BIT];
	wire logic run1 = ctrl_q[`DTC_RUN_ONE_BIT];
	wire logic split0 = (mode0 == DTC_MODE_SPLIT);

	// ==============================
	// Count enables
	// run and gating
	wire logic en0 = run0 && (!gate0 || EXT_IRQ_PIN_ZERO);
	// timer 1 halts in mode 11
	wire logic en1 = run1 && (!gate1 || EXT_IRQ_PIN_ONE) && (mode1 != DTC_MODE_SPLIT);
	// machine cycles or own pin edges
	// edge detected in one cycle counts at the next
	wire logic tick0 = en0 && mc_en && (!sel0 || fall[0]);
	wire logic tick1 = en1 && mc_en && (!sel1 || fall[1]);
	// split high byte counts machine cycles under timer 1 run
	wire logic tick_hi0 = split0 && run1 && mc_en;

	wire dtc_step_t step0 = count_step(mode0, hi0_q, lo0_q);
	wire dtc_step_t step1 = count_step(mode1, hi1_q, lo1_q);

	wire logic ovf0_set = tick0 && step0.ovf;
	wire logic ovf1_own = tick1 && step1.ovf;
	// split high byte takes over timer 1 flag
	wire logic ovf1_set = split0 ? (tick_hi0 && (hi0_q == 8'hFF)) : ovf1_own;

	// ==============================
	// Count byte next values
	// software write wins
	// run bit writes never touch counts
	assign lo0_d = wr_lo0 ? SFR_REQ.wdata : (tick0 ? step0.lo : lo0_q);
	assign hi0_d = wr_hi0 ? SFR_REQ.wdata :
		split0 ? (tick_hi0 ? hi0_q + 8'h01 : hi0_q) :
		(tick0 ? step0.hi : hi0_q);
	assign lo1_d = wr_lo1 ? SFR_REQ.wdata : (tick1 ? step1.lo : lo1_q);
	assign hi1_d = wr_hi1 ? SFR_REQ.wdata : (tick1 ? step1.hi : hi1_q);

	// ==============================
	// External interrupt detection
	// type 1 falling edge, type 0 low level
	wire logic ext0_set = mc_en &&
		(ctrl_q[`DTC_TYPE_ZERO_BIT] ? fall[2] : !level[2]);
	wire logic ext1_set = mc_en &&
		(ctrl_q[`DTC_TYPE_ONE_BIT] ? fall[3] : !level[3]);

	// ==============================
	// Control flags next value
	wire logic [7:0] ctrl_base = wr_ctrl ? SFR_REQ.wdata : ctrl_q;
	always_comb
	begin
		// run and type bits as software wrote them
		ctrl_d = ctrl_base;
		ctrl_d[`DTC_OVF_ZERO_BIT] = (ctrl_base[`DTC_OVF_ZERO_BIT] && !ACK_OVF_ZERO) || ovf0_set;
		ctrl_d[`DTC_OVF_ONE_BIT] = (ctrl_base[`DTC_OVF_ONE_BIT] && !ACK_OVF_ONE) || ovf1_set;
		ctrl_d[`DTC_EXT_ZERO_BIT] = (ctrl_base[`DTC_EXT_ZERO_BIT] && !ACK_EXT_ZERO) || ext0_set;
		ctrl_d[`DTC_EXT_ONE_BIT] = (ctrl_base[`DTC_EXT_ONE_BIT] && !ACK_EXT_ONE) || ext1_set;
	end

	// ==============================
	// Read data
	always_comb
	begin
		case (SFR_REQ.addr)
			`DTC_ADDR_CTRL_FLAGS: rdata_d = ctrl_q;
			`DTC_ADDR_MODE_SEL: rdata_d = mode_q;
			`DTC_ADDR_CNT0_LO: rdata_d = lo0_q;
			`DTC_ADDR_CNT0_HI: rdata_d = hi0_q;
			`DTC_ADDR_CNT1_LO: rdata_d = lo1_q;
			`DTC_ADDR_CNT1_HI: rdata_d = hi1_q;
			default: rdata_d = 8'h00;
		endcase
	end

	// ==============================
	// State registers
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			ctrl_q <= `DTC_CTRL_RESET;
			mode_q <= `DTC_MODE_RESET;
			lo0_q <= `DTC_CNT_RESET;
			hi0_q <= `DTC_CNT_RESET;
			lo1_q <= `DTC_CNT_RESET;
			hi1_q <= `DTC_CNT_RESET;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			mode_q <= wr_mode ? SFR_REQ.wdata : mode_q;
			lo0_q <= lo0_d;
			hi0_q <= hi0_d;
			lo1_q <= lo1_d;
			hi1_q <= hi1_d;
		end
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			rdata_q <= 8'h00;
			serial_q <= 1'b0;
		end
		else
		begin
			rdata_q <= SFR_REQ.rd ? rdata_d : rdata_q;
			// timer 1 overflow to serial port, also in split
			serial_q <= ovf1_own;
		end
	end

	// ==============================
	// Outputs
	assign SFR_RDATA = rdata_q;
	assign OVF_REQ_ZERO = ctrl_q[`DTC_OVF_ZERO_BIT];
	assign OVF_REQ_ONE = ctrl_q[`DTC_OVF_ONE_BIT];
	assign EXT_REQ_ZERO = ctrl_q[`DTC_EXT_ZERO_BIT];
	assign EXT_REQ_ONE = ctrl_q[`DTC_EXT_ONE_BIT];
	assign SERIAL_TICK = serial_q;
endmodule

`default_nettype wire

// ==== hdl/dtc_cfg.svh ====
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// ==============================
// Register offsets
`define DTC_ADDR_CTRL_FLAGS 8'h88
`define DTC_ADDR_MODE_SEL 8'h89
`define DTC_ADDR_CNT0_LO 8'h8A
`define DTC_ADDR_CNT1_LO 8'h8B
`define DTC_ADDR_CNT0_HI 8'h8C
`define DTC_ADDR_CNT1_HI 8'h8D

// ==============================
// Reset values
`define DTC_CTRL_RESET 8'h00
`define DTC_MODE_RESET 8'h00
`define DTC_CNT_RESET 8'h00

// ==============================
// Control flags register fields
`define DTC_OVF_ONE_BIT 7
`define DTC_RUN_ONE_BIT 6
`define DTC_OVF_ZERO_BIT 5
`define DTC_RUN_ZERO_BIT 4
`define DTC_EXT_ONE_BIT 3
`define DTC_TYPE_ONE_BIT 2
`define DTC_EXT_ZERO_BIT 1
`define DTC_TYPE_ZERO_BIT 0

// ==============================
// Mode select register fields
`define DTC_GATE_ONE_BIT 7
`define DTC_SEL_ONE_BIT 6
`define DTC_MODE_ONE_HI 5
`define DTC_MODE_ONE_LO 4
`define DTC_GATE_ZERO_BIT 3
`define DTC_SEL_ZERO_BIT 2
`define DTC_MODE_ZERO_HI 1
`define DTC_MODE_ZERO_LO 0

// ==============================
// Timing: oscillator periods per machine cycle
`define DTC_CYCLE_CLKS 6

`endif

// ==== hdl/dtc_pkg.sv ====
package dtc_pkg;

	// ==============================
	// Operating modes of one timer
	typedef enum logic [1:0]
	{
		DTC_MODE_13BIT,
		DTC_MODE_16BIT,
		DTC_MODE_RELOAD,
		DTC_MODE_SPLIT
	} dtc_mode_t;

	// ==============================
	// Register access request from the core
	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dtc_sfr_req_t;

	// ==============================
	// Result of one count step
	typedef struct packed
	{
		logic [7:0] hi;
		logic [7:0] lo;
		logic ovf;
	} dtc_step_t;

endpackage

// ==== hdl/dtc_cycle_div.sv ====
`timescale 1ns/1ps
`default_nettype none

// Machine cycle enable: one pulse every CYCLE_CLKS clocks
module dtc_cycle_div #(
	parameter int CYCLE_CLKS = 6
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Enable pulse
	output logic en_q
);
	localparam int CW = (CYCLE_CLKS > 2) ? $clog2(CYCLE_CLKS) : 1;
	localparam logic [CW-1:0] LAST = CW'(CYCLE_CLKS - 1);

	logic [CW-1:0] cnt_q;
	wire logic wrap = (cnt_q == LAST);

	generate
		if (CYCLE_CLKS < 2)
		begin : g_bad_div
			$error("dtc_cycle_div: CYCLE_CLKS must be at least 2");
		end
	endgenerate

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= '0;
			en_q <= 1'b0;
		end
		else
		begin
			cnt_q <= wrap ? '0 : cnt_q + CW'(1);
			en_q <= wrap;
		end
	end
endmodule

`default_nettype wire

// ==== hdl/dtc_pin_sampler.sv ====
`timescale 1ns/1ps
`default_nettype none

// Samples a pin once per machine cycle and flags a high-then-low pair
module dtc_pin_sampler (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Machine cycle enable and pin
	input wire logic mc_en,
	input wire logic pin,
	// Sampled level and falling edge, held for one machine cycle
	output logic level_q,
	output logic fall_q
);
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			level_q <= 1'b1;
			fall_q <= 1'b0;
		end
		else if (mc_en)
		begin
			level_q <= pin;
			fall_q <= level_q & ~pin;
		end
	end
endmodule

`default_nettype wire

// ==== test/dtc_timer_unit_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_unit_properties #(
	parameter int CYCLE_CLKS = 6
) (
	// Clock, reset and bus
	input wire logic CLK,
	input wire logic RST,
	input wire dtc_pkg::dtc_sfr_req_t SFR_REQ,
	input wire logic [7:0] SFR_RDATA,
	// Service and requests
	input wire logic ACK_OVF_ZERO,
	input wire logic ACK_OVF_ONE,
	input wire logic OVF_REQ_ZERO,
	input wire logic OVF_REQ_ONE,
	input wire logic SERIAL_TICK
);
	import dtc_pkg::*;
	// ====
	// Shadows of software-only bits
	logic run0_q, run1_q;
	logic [7:0] mode_q;
	wire logic wr_ctl = SFR_REQ.wr && SFR_REQ.addr == 8'h88;
	wire logic set0 = wr_ctl && SFR_REQ.wdata[5];
	wire logic far = SFR_REQ.addr < 8'h88 || SFR_REQ.addr > 8'h8D;
	wire logic t1_live = run1_q && mode_q[5:4] != 2'b11;
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			run0_q <= 1'b0;
			run1_q <= 1'b0;
			mode_q <= 8'h00;
		end
		else
		begin
			if (wr_ctl)
			begin
				run0_q <= SFR_REQ.wdata[4];
				run1_q <= SFR_REQ.wdata[6];
			end
			if (SFR_REQ.wr && SFR_REQ.addr == 8'h89)
				mode_q <= SFR_REQ.wdata;
		end
	end
	// ====
	// Properties
	default clocking @(posedge CLK);
	endclocking
	default disable iff (RST);
	sequence s_rd_ctl;
		SFR_REQ.rd && SFR_REQ.addr == 8'h88;
	endsequence
	a_reset_quiet: assert property (disable iff (1'b0)
		RST |=> SFR_RDATA == 8'h00 && !OVF_REQ_ZERO && !OVF_REQ_ONE && !SERIAL_TICK)
		else $error("outputs not cleared in reset");
	a_mode_read_back: assert property (
		SFR_REQ.rd && SFR_REQ.addr == 8'h89 |=> SFR_RDATA == $past(mode_q))
		else $error("mode readback differs");
	a_run_bits_read: assert property (
		s_rd_ctl |=> SFR_RDATA[6] == $past(run1_q) && SFR_RDATA[4] == $past(run0_q))
		else $error("run bits readback differs");
	a_rdata_holds: assert property (!SFR_REQ.rd |=> $stable(SFR_RDATA))
		else $error("read data moved without read");
	a_unmapped_zero: assert property (SFR_REQ.rd && far |=> SFR_RDATA == 8'h00)
		else $error("unmapped read not zero");
	a_ovf0_ack_clear: assert property (
		ACK_OVF_ZERO && !run0_q && !wr_ctl |=> !OVF_REQ_ZERO)
		else $error("ack did not clear flag zero");
	a_ovf1_ack_clear: assert property (
		ACK_OVF_ONE && !run1_q && !wr_ctl |=> !OVF_REQ_ONE)
		else $error("ack did not clear flag one");
	a_ovf0_needs_run: assert property (
		$rose(OVF_REQ_ZERO) |-> $past(run0_q) || $past(set0))
		else $error("flag zero set while stopped");
	a_tick_single: assert property (
		SERIAL_TICK |-> $past(t1_live, 2) ##1 !SERIAL_TICK)
		else $error("serial tick wrong");
endmodule
bind dtc_timer_unit dtc_timer_unit_properties #(.CYCLE_CLKS(CYCLE_CLKS))
	dtc_timer_unit_properties_i (.CLK(CLK), .RST(RST), .SFR_REQ(SFR_REQ),
	.SFR_RDATA(SFR_RDATA), .ACK_OVF_ZERO(ACK_OVF_ZERO), .ACK_OVF_ONE(ACK_OVF_ONE),
	.OVF_REQ_ZERO(OVF_REQ_ZERO), .OVF_REQ_ONE(OVF_REQ_ONE), .SERIAL_TICK(SERIAL_TICK));
`default_nettype wire

// ==== test/dtc_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dtc_core_model (
	// Clock
	input wire logic clk,
	// Register bus and service
	output dtc_pkg::dtc_sfr_req_t req,
	input wire logic [7:0] rdata,
	output logic [3:0] ack
);
	import dtc_pkg::*;
	initial
	begin
		req = '0;
		ack = 4'h0;
	end
	// Held across the taking edge, then scrambled
	task automatic access(input logic w, input logic [7:0] a, d, output logic [7:0] q);
		@(negedge clk);
		req = {w, ~w, a, d};
		@(negedge clk);
		q = rdata;
		req = {2'b00, ~a, ~d};
	endtask
	task automatic pulse(input logic [3:0] v);
		@(negedge clk);
		ack = v;
		@(negedge clk);
		ack = 4'h0;
	endtask
endmodule
`default_nettype wire

// ==== test/dtc_timer_unit_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_unit_bench;
	import dtc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cp0 = 1'b0;
	logic ep0 = 1'b1;
	logic ep1 = 1'b1;
	dtc_sfr_req_t req;
	logic [7:0] rdata, lo, hi;
	logic [3:0] ack;
	logic oq0, oq1, eq0, eq1, tick;
	int n_mismatch = 0;
	int cmp_count = 0;
	int n_tick = 0;
	int cyc = 0;
	always #5 clk = ~clk;
	dtc_timer_unit #(.CYCLE_CLKS(6)) dtc_timer_unit_i (.CLK(clk), .RST(rst),
		.SFR_REQ(req), .SFR_RDATA(rdata), .COUNT_PIN_ZERO(cp0), .COUNT_PIN_ONE(1'b0),
		.EXT_IRQ_PIN_ZERO(ep0), .EXT_IRQ_PIN_ONE(ep1), .ACK_OVF_ZERO(ack[0]),
		.ACK_OVF_ONE(ack[1]), .ACK_EXT_ZERO(ack[2]), .ACK_EXT_ONE(ack[3]),
		.OVF_REQ_ZERO(oq0), .OVF_REQ_ONE(oq1), .EXT_REQ_ZERO(eq0),
		.EXT_REQ_ONE(eq1), .SERIAL_TICK(tick));
	dtc_core_model dtc_core_model_i (.clk(clk), .req(req), .rdata(rdata), .ack(ack));
	always @(posedge clk)
	begin
		cyc++;
		if (tick === 1'b1)
			n_tick++;
		if (cyc == 5000)
		begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic summarize;
		$display("mismatches %0d, compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		logic [7:0] q;
		dtc_core_model_i.access(1'b1, a, d, q);
	endtask
	task automatic rdc(input logic [7:0] a, exp);
		logic [7:0] q;
		dtc_core_model_i.access(1'b0, a, 8'h00, q);
		check(q, exp);
	endtask
	// ====
	// Scenarios
	task automatic t_regs;
		for (logic [7:0] a = 8'h88; a < 8'h8E; a++)
			rdc(a, 8'h00);
		wr(8'h89, 8'hA5);
		rdc(8'h89, 8'hA5);
		for (logic [7:0] a = 8'h8A; a < 8'h8E; a++)
		begin
			wr(a, a ^ 8'h5A);
			rdc(a, a ^ 8'h5A);
		end
		wr(8'h90, 8'h3C);
		rdc(8'h90, 8'h00);
	endtask
	// Runs to overflow, stops ten machine cycles later
	task automatic run_ovf(input logic t, input logic [7:0] m, c, h, l, la, ha);
		int n;
		wr(8'h89, m);
		wr(ha, h);
		wr(la, l);
		wr(8'h88, c);
		n = 0;
		while ((t ? oq1 : oq0) !== 1'b1 && n < 400)
		begin
			@(negedge clk);
			n++;
		end
		check({7'h00, t ? oq1 : oq0}, 8'h01);
		repeat (58) @(negedge clk);
		wr(8'h88, t ? 8'h80 : 8'h20);
		check({7'h00, t ? oq1 : oq0}, 8'h01);
		dtc_core_model_i.pulse(t ? 4'h2 : 4'h1);
		check({7'h00, t ? oq1 : oq0}, 8'h00);
		dtc_core_model_i.access(1'b0, la, 8'h00, lo);
		dtc_core_model_i.access(1'b0, ha, 8'h00, hi);
	endtask
	task automatic pin_pulse;
		cp0 = 1'b1;
		repeat (12) @(negedge clk);
		cp0 = 1'b0;
		repeat (18) @(negedge clk);
	endtask
	task automatic t_counter;
		wr(8'h89, 8'h0D);
		wr(8'h8C, 8'hFF);
		wr(8'h8A, 8'hFF);
		ep0 = 1'b0;
		wr(8'h88, 8'h10);
		pin_pulse();
		check({7'h00, oq0}, 8'h00);
		ep0 = 1'b1;
		pin_pulse();
		check({7'h00, oq0}, 8'h01);
		wr(8'h88, 8'h00);
		rdc(8'h8A, 8'h00);
	endtask
	task automatic t_ext;
		wr(8'h88, 8'h04);
		ep0 = 1'b0;
		ep1 = 1'b0;
		repeat (18) @(negedge clk);
		check({6'h00, eq1, eq0}, 8'h03);
		dtc_core_model_i.pulse(4'hC);
		repeat (18) @(negedge clk);
		check({6'h00, eq1, eq0}, 8'h01);
	endtask
	// ====
	// Main sequence
	initial
	begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		t_regs();
		run_ovf(1'b0, 8'h01, 8'h10, 8'hFF, 8'hFE, 8'h8A, 8'h8C);
		check(lo, 8'h0A);
		check(hi, 8'h00);
		run_ovf(1'b1, 8'h00, 8'h40, 8'hFF, 8'hFE, 8'h8B, 8'h8D);
		check(lo, 8'hEA);
		check(n_tick[7:0], 8'h01);
		run_ovf(1'b0, 8'h02, 8'h10, 8'h80, 8'hFE, 8'h8A, 8'h8C);
		check({lo, hi}, 16'h8A80);
		run_ovf(1'b1, 8'h33, 8'h40, 8'hFE, 8'h55, 8'h8A, 8'h8C);
		check({lo, hi}, 16'h550A);
		rdc(8'h8B, 8'hEA);
		check(n_tick[7:0], 8'h01);
		t_counter();
		t_ext();
		summarize();
	end
endmodule
`default_nettype wire
